/* File: dpdt_timer.sv */
// two prescaled 8-bit down timers on the core data space
`include "dpdt_timer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dpdt_timer
    import dpdt_timer_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic irq_vector3,
    output logic irq_vector1,
    output logic wait_wakeup
);

    // true when addr names the given location
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] loc
    );
        addr_hit = (addr == loc);
    endfunction

    // rising edge of the selected counter clock source
    function automatic logic tap_rise(
        input logic [2:0] sel,
        input logic tick,
        input logic [6:0] cur,
        input logic [6:0] nxt
    );
        logic [2:0] idx;
        idx = sel - 3'h1;
        if (sel == DPDT_DIV_1) begin
            tap_rise = tick;
        end else begin
            tap_rise = tick & ~cur[idx] & nxt[idx];
        end
    endfunction

    // one less, wrapping through zero; shared by counter and prescaler
    function automatic logic [7:0] dec_one(
        input logic [7:0] value
    );
        dec_one = value - 8'h01;
    endfunction

    // oscillator divider state
    logic [3:0] osc_div_reg;
    logic [3:0] osc_div_next;
    logic div_tick;

    // per-unit state gathered for the read mux
    dpdt_byte_t cnt_all [2];
    dpdt_presc_t psc_all [2];
    dpdt_byte_t ctl_all [2];

    // registered outputs
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq3_reg;
    logic irq1_reg;
    logic wake_reg;
    logic irq3_next;
    logic irq1_next;
    logic wake_next;

    // global enable from the first unit only
    logic glob_en;

    // address decode for all six locations
    logic [1:0] sel_psc;
    logic [1:0] sel_cnt;
    logic [1:0] sel_ctl;

    assign sel_psc[0] = addr_hit(bus_addr, `DPDT_T1_PRESC_ADDR);
    assign sel_cnt[0] = addr_hit(bus_addr, `DPDT_T1_COUNT_ADDR);
    assign sel_ctl[0] = addr_hit(bus_addr, `DPDT_T1_CTRL_ADDR);
    assign sel_psc[1] = addr_hit(bus_addr, `DPDT_T2_PRESC_ADDR);
    assign sel_cnt[1] = addr_hit(bus_addr, `DPDT_T2_COUNT_ADDR);
    assign sel_ctl[1] = addr_hit(bus_addr, `DPDT_T2_CTRL_ADDR);

    // enable only for bit 4 set with bit 5 clear
    assign glob_en = ctl_all[0][`DPDT_EN_LO_BIT] &
                     ~ctl_all[0][`DPDT_EN_HI_BIT];

    // oscillator over 12: one tick per twelve clocks
    assign div_tick = (osc_div_reg == `DPDT_OSC_DIV_LAST);
    assign osc_div_next = div_tick ? 4'h0 : osc_div_reg + 4'h1;

    // free-running divide-by-12 counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_div_reg <= 4'h0;
        end else begin
            osc_div_reg <= osc_div_next;
        end
    end

    // two units, alike but for the control write mask
    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            logic [7:0] cnt_reg;
            logic [7:0] cnt_next;
            logic [6:0] psc_reg;
            logic [6:0] psc_next;
            logic [7:0] ctl_reg;
            logic [7:0] ctl_next;
            logic [7:0] ctl_mask;
            logic wr_psc;
            logic wr_cnt;
            logic wr_ctl;
            logic prescaler_initialise_bit;
            logic run;
            logic psc_dec;
            logic [6:0] psc_minus;
            logic [7:0] cnt_minus;
            logic cnt_step;
            logic dec_to_zero;
            logic zero_set;
            logic zero_next;

            // write strobes for this unit
            assign wr_psc = bus_wr & sel_psc[u];
            assign wr_cnt = bus_wr & sel_cnt[u];
            assign wr_ctl = bus_wr & sel_ctl[u];

            // second unit keeps no global enable bits 5:4
            assign ctl_mask = (u == 0) ? `DPDT_T1_CTRL_MASK :
                                         `DPDT_T2_CTRL_MASK;

            // running needs global enable and initialise bit
            assign prescaler_initialise_bit = ctl_reg[`DPDT_PSI_BIT];
            assign run = glob_en & prescaler_initialise_bit;
            assign psc_dec = run & div_tick;
            assign psc_minus = 7'(dec_one({1'b0, psc_reg})); // 00 -> 7F
            assign cnt_minus = dec_one(cnt_reg); // 00 -> FF

            // counter clock from the selected tap
            assign cnt_step = run & tap_rise(
                ctl_reg[`DPDT_DIV_MSB:`DPDT_DIV_LSB],
                psc_dec, psc_reg, psc_minus);

            // prescaler: preset while not initialised, else load, count down or hold
            assign psc_next = !prescaler_initialise_bit ? `DPDT_PRESC_RESET :
                              wr_psc ? bus_wdata[6:0] :
                              psc_dec ? psc_minus :
                              psc_reg;

            // counter: software write wins over a step
            assign cnt_next = wr_cnt ? bus_wdata :
                              cnt_step ? cnt_minus :
                              cnt_reg;

            // decrement landing on zero, unless overwritten
            assign dec_to_zero = cnt_step & ~wr_cnt &
                                 (cnt_reg == 8'h01);

            // any source that sets the zero flag
            assign zero_set = dec_to_zero |
                              (wr_cnt & (bus_wdata == 8'h00)) |
                              (wr_ctl & bus_wdata[`DPDT_ZERO_BIT]);

            // set beats a software clear in the same cycle
            assign zero_next = zero_set ? 1'b1 :
                               wr_ctl ? 1'b0 :
                               ctl_reg[`DPDT_ZERO_BIT];

            // control register with flag merged in
            always_comb begin
                ctl_next = ctl_reg;
                if (wr_ctl) begin
                    ctl_next = bus_wdata & ctl_mask;
                end
                ctl_next[`DPDT_ZERO_BIT] = zero_next;
            end

            // unit state, stopped after reset
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_reg <= `DPDT_COUNT_RESET;
                    psc_reg <= `DPDT_PRESC_RESET;
                    ctl_reg <= `DPDT_CTRL_RESET;
                end else begin
                    cnt_reg <= cnt_next;
                    psc_reg <= psc_next;
                    ctl_reg <= ctl_next;
                end
            end

            // expose state for read-back and requests
            assign cnt_all[u] = cnt_reg;
            assign psc_all[u] = psc_reg;
            assign ctl_all[u] = ctl_reg;
        end
    endgenerate

    // live read-back; unmapped locations read zero
    logic [7:0] rd_mux;
    assign rd_mux = sel_psc[0] ? {1'b0, psc_all[0]} :
                    sel_cnt[0] ? cnt_all[0] :
                    sel_ctl[0] ? ctl_all[0] :
                    sel_psc[1] ? {1'b0, psc_all[1]} :
                    sel_cnt[1] ? cnt_all[1] :
                    sel_ctl[1] ? ctl_all[1] :
                    8'h00;

    // read data returned the cycle after the strobe
    assign rdata_next = bus_rd ? rd_mux : 8'h00;

    // requests follow enable and flag of each unit
    assign irq3_next = ctl_all[0][`DPDT_IE_BIT] &
                       ctl_all[0][`DPDT_ZERO_BIT];
    assign irq1_next = ctl_all[1][`DPDT_IE_BIT] &
                       ctl_all[1][`DPDT_ZERO_BIT];

    // any pending request ends the wait state
    assign wake_next = irq3_next | irq1_next;

    // output flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
            irq3_reg <= 1'b0;
            irq1_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq3_reg <= irq3_next;
            irq1_reg <= irq1_next;
            wake_reg <= wake_next;
        end
    end

    // ports straight from flops
    assign bus_rdata = rdata_reg;
    assign irq_vector3 = irq3_reg;
    assign irq_vector1 = irq1_reg;
    assign wait_wakeup = wake_reg;

endmodule

`default_nettype wire

/* File: dpdt_timer_asserts.sv */
// concurrent checks on the dual timer data-space port
`timescale 1ns/1ps
`default_nettype none
module dpdt_timer_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic irq_vector3,
    input wire logic irq_vector1,
    input wire logic wait_wakeup
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // address decode of the six timer locations
    wire logic mapped = bus_addr inside {8'hd2, 8'hd3, 8'hd4, 8'hda,
        8'hdb, 8'hdc};
    wire logic presc_rd = bus_rd && (bus_addr == 8'hd2 || bus_addr == 8'hda);
    // control write of flag and enable bits, then a quiet cycle
    sequence ctl_wr(a, v);
        bus_wr && bus_addr == a && bus_wdata[7:6] == v ##1 !bus_wr;
    endsequence
    // zero written to counter one, its control read two cycles on
    sequence zero_then_rd;
        bus_wr && bus_addr == 8'hd3 && bus_wdata == 8'h00 ##1 !bus_wr
        ##1 bus_rd && !bus_wr && bus_addr == 8'hd4;
    endsequence
    wake_tracks_irq_a:
        assert property (wait_wakeup == (irq_vector3 | irq_vector1))
        else $error("wakeup differs from requests");
    idle_rdata_a:
        assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data not zero when idle");
    unmapped_read_a:
        assert property (bus_rd && !mapped |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    presc_msb_a:
        assert property (presc_rd |=> !bus_rdata[7])
        else $error("prescaler top bit not zero");
    ctrl2_unimpl_a:
        assert property (bus_rd && bus_addr == 8'hdc
            |=> bus_rdata[5:4] == 2'b00)
        else $error("second control bits 5:4 set");
    zero_write_a:
        assert property (zero_then_rd |=> bus_rdata[7])
        else $error("zero write did not set flag");
    irq3_raise_a:
        assert property (ctl_wr(8'hd4, 2'b11) |=> irq_vector3)
        else $error("vector3 request missing");
    irq3_mask_a:
        assert property (ctl_wr(8'hd4, 2'b00) |=> !irq_vector3)
        else $error("vector3 request while disabled");
    irq1_raise_a:
        assert property (ctl_wr(8'hdc, 2'b11) |=> irq_vector1)
        else $error("vector1 request missing");
endmodule
bind dpdt_timer dpdt_timer_asserts dpdt_timer_asserts_i (.clk(clk),
    .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .irq_vector3(irq_vector3), .irq_vector1(irq_vector1),
    .wait_wakeup(wait_wakeup));
`default_nettype wire

/* File: dpdt_timer_cfg.svh */
// offsets, field positions, reset values and counts of the dual timer
`ifndef DPDT_TIMER_CFG_SVH
`define DPDT_TIMER_CFG_SVH

// data-space locations, first unit
`define DPDT_T1_PRESC_ADDR 8'hd2
`define DPDT_T1_COUNT_ADDR 8'hd3
`define DPDT_T1_CTRL_ADDR 8'hd4
// data-space locations, second unit
`define DPDT_T2_PRESC_ADDR 8'hda
`define DPDT_T2_COUNT_ADDR 8'hdb
`define DPDT_T2_CTRL_ADDR 8'hdc

// status/control field positions
`define DPDT_ZERO_BIT 7
`define DPDT_IE_BIT 6
`define DPDT_EN_HI_BIT 5
`define DPDT_EN_LO_BIT 4
`define DPDT_PSI_BIT 3
`define DPDT_DIV_MSB 2
`define DPDT_DIV_LSB 0

// writable bits of each control register
`define DPDT_T1_CTRL_MASK 8'hff
`define DPDT_T2_CTRL_MASK 8'hcf

// reset values
`define DPDT_COUNT_RESET 8'hff
`define DPDT_PRESC_RESET 7'h7f
`define DPDT_CTRL_RESET 8'h00

// oscillator divided by 12 feeds the prescaler
`define DPDT_OSC_DIVIDE 12
`define DPDT_OSC_DIV_LAST 4'hb

`endif

/* File: dpdt_timer_pkg.sv */
// types shared by the dual prescaled down timer
`default_nettype none
package dpdt_timer_pkg;

    typedef logic [7:0] dpdt_byte_t;
    typedef logic [6:0] dpdt_presc_t;

    // division select codes
    typedef enum logic [2:0] {
        DPDT_DIV_1 = 3'b000,
        DPDT_DIV_2 = 3'b001,
        DPDT_DIV_4 = 3'b010,
        DPDT_DIV_8 = 3'b011,
        DPDT_DIV_16 = 3'b100,
        DPDT_DIV_32 = 3'b101,
        DPDT_DIV_64 = 3'b110,
        DPDT_DIV_128 = 3'b111
    } dpdt_div_t;

endpackage

`default_nettype wire

/* File: test_dual_prescaled_down_timer.sv */
// self-checking bench for the dual prescaled down timer
`timescale 1ns/1ps
`default_nettype none
module test_dual_prescaled_down_timer;
    logic clk, resetn, bus_wr, bus_rd, irq_vector3, irq_vector1, wait_wakeup;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    int num_errors = 0;
    int check_count = 0;
    logic [7:0] ra [7] = '{8'hd2, 8'hd3, 8'hd4, 8'hda, 8'hdb, 8'hdc, 8'hd5};
    logic [7:0] re [7] = '{8'h7f, 8'hff, 8'h00, 8'h7f, 8'hff, 8'h00, 8'h00};
    dpdt_timer dpdt_timer_i (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_vector3(irq_vector3),
        .irq_vector1(irq_vector1), .wait_wakeup(wait_wakeup));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle strobed bus accesses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 check(bus_rdata, e);
    endtask
    // stop, load counter with 2, then start with control value c
    task automatic arm(input logic [7:0] c);
        wr(8'hd4, 8'h00);
        wr(8'hd3, 8'h02);
        wr(8'hd4, c);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
    // main sequence
    initial begin
        resetn = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) rc(ra[i], re[i]);
        wr(8'hd2, 8'h10);
        rc(8'hd2, 8'h7f);
        wr(8'hdc, 8'h3f);
        rc(8'hdc, 8'h0f);
        wr(8'hdb, 8'h00);
        rc(8'hdc, 8'h8f);
        wr(8'hdc, 8'hc0);
        rc(8'hdc, 8'hc0);
        check({6'h00, irq_vector1, wait_wakeup}, 8'h03);
        wr(8'hdc, 8'h00);
        rc(8'hdc, 8'h00);
        check({6'h00, irq_vector1, wait_wakeup}, 8'h00);
        wr(8'hd3, 8'h00);
        rc(8'hd4, 8'h80);
        wr(8'hd4, 8'hc0);
        rc(8'hd4, 8'hc0);
        check({7'h00, irq_vector3}, 8'h01);
        wr(8'hd3, 8'h05);
        rc(8'hd3, 8'h05);
        wr(8'hd4, 8'h28);
        wr(8'hd2, 8'h05);
        rc(8'hd2, 8'h05);
        foreach (re[i]) if (i < 3) begin
            // enable bits 00, 10 (bit5 only) and 11 must all stay stopped
            arm(8'h08 | (i > 0 ? 8'h20 : 8'h00) | (i == 2 ? 8'h10 : 8'h00));
            repeat (40) @(posedge clk);
            rc(8'hd3, 8'h02);
        end
        // each division code: flag absent just before, present just after
        for (int n = 0; n < 8; n++) begin
            arm(8'h58 | 8'(n));
            repeat (24 * (1 << n) - 14) @(posedge clk);
            rc(8'hd4, 8'h58 | 8'(n));
            check({7'h00, irq_vector3}, 8'h00);
            repeat (11) @(posedge clk);
            rc(8'hd4, 8'hd8 | 8'(n));
            check({7'h00, irq_vector3}, 8'h01);
            // live counter read; steps are at least 24 cycles apart
            if (n > 0) begin
                rc(8'hd3, 8'h00);
            end
        end
        // counter rewritten with 01 over a full tick period: no flag
        arm(8'h58);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= 8'hd3;
        bus_wdata <= 8'h01;
        repeat (13) @(posedge clk);
        bus_wdata <= 8'h05;
        @(posedge clk);
        bus_wr <= 1'b0;
        rc(8'hd4, 8'h58);
        check({7'h00, irq_vector3}, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
